/* File: rtl/pia_powerup_init.sv */
// power-up sequencer, configuration load and bus address setup
`timescale 1ns/100ps
module pia_powerup_init (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // analog monitor comparators, asynchronous
    input wire logic bias_rail_ok_in,
    input wire logic core_rail_1v8_ok_in,
    input wire logic osc_stable_in,
    input wire logic enable_ok_in,
    input wire logic input_rail_ok_in,
    // nonvolatile configuration store read port
    output logic nvm_rd_out,
    output logic [1:0] nvm_index_out,
    input wire logic nvm_ack_in,
    input wire logic [7:0] nvm_data_in,
    // address resistor converter
    output logic adc_start_out,
    input wire logic adc_done_in,
    input wire logic [9:0] adc_code_in,
    // management command port from the bus engines
    input wire logic mgmt_wr_in,
    input wire logic mgmt_rd_in,
    input wire logic [1:0] mgmt_index_in,
    input wire logic [7:0] mgmt_wdata_in,
    output logic [7:0] mgmt_rdata_out,
    output logic mgmt_rvalid_out,
    // received address filter
    input wire logic bus_addr_valid_in,
    input wire logic bus_is_power_bus_in,
    input wire logic [6:0] bus_addr_in,
    output logic bus_addr_hit_out,
    // status
    output logic por_active_out,
    output logic load_done_out,
    output logic addr_read_out,
    output logic conversion_on_out,
    output logic [6:0] twowire_addr_out,
    output logic [6:0] power_bus_addr_out,
    output logic twowire_enabled_out,
    output logic power_bus_enabled_out
);

    // ------------------------------------------------------------
    // monitor synchronisers
    // ------------------------------------------------------------
    logic [4:0] mon_meta_reg;
    logic [4:0] mon_sync_reg;
    logic [4:0] mon_raw;

    assign mon_raw = {input_rail_ok_in, enable_ok_in, osc_stable_in,
                      core_rail_1v8_ok_in, bias_rail_ok_in};

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            mon_meta_reg <= 5'h00;
            mon_sync_reg <= 5'h00;
        end
        else
        begin
            mon_meta_reg <= mon_raw;
            mon_sync_reg <= mon_meta_reg;
        end
    end

    logic supplies_good;

    // all three must hold before the sequencer may leave reset
    assign supplies_good = mon_sync_reg[pia_pkg::MON_BIAS]
                         & mon_sync_reg[pia_pkg::MON_CORE]
                         & mon_sync_reg[pia_pkg::MON_OSC];

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    pia_pkg::pia_state_e state_reg;
    pia_pkg::pia_state_e state_next;
    logic [1:0] load_idx_reg;
    logic load_done_reg;
    logic addr_read_reg;
    logic [3:0] offset_reg;
    logic nvm_rd_reg;
    logic adc_start_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pia_pkg::ST_POR:
                if (supplies_good)
                    state_next = pia_pkg::ST_LOAD_REQ;
            pia_pkg::ST_LOAD_REQ:
                if (nvm_ack_in && load_idx_reg == pia_pkg::IDX_LAST_LOADED)
                    state_next = pia_pkg::ST_ADC_START;
            pia_pkg::ST_ADC_START:
                state_next = pia_pkg::ST_ADC_WAIT;
            pia_pkg::ST_ADC_WAIT:
                if (adc_done_in)
                    state_next = pia_pkg::ST_READY;
            pia_pkg::ST_READY:
                state_next = pia_pkg::ST_READY;
            default:
                state_next = pia_pkg::ST_POR;
        endcase
        // a supply drop anywhere restarts the whole sequence
        if (!supplies_good)
            state_next = pia_pkg::ST_POR;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            state_reg <= pia_pkg::ST_POR;
        else
            state_reg <= state_next;
    end

    // load walks every word of the store in index order
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || state_reg == pia_pkg::ST_POR)
            load_idx_reg <= 2'h0;
        else if (state_reg == pia_pkg::ST_LOAD_REQ && nvm_ack_in)
            load_idx_reg <= load_idx_reg + 2'h1;
    end

    // read request is a level held until the store acknowledges
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            nvm_rd_reg <= 1'b0;
        else
            nvm_rd_reg <= (state_next == pia_pkg::ST_LOAD_REQ) && !nvm_ack_in;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || !supplies_good)
            load_done_reg <= 1'b0;
        else if (state_reg == pia_pkg::ST_LOAD_REQ && state_next == pia_pkg::ST_ADC_START)
            load_done_reg <= 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            adc_start_reg <= 1'b0;
        else
            adc_start_reg <= (state_next == pia_pkg::ST_ADC_START) && supplies_good;
    end

    // ------------------------------------------------------------
    // address offset capture
    // ------------------------------------------------------------
    pia_adc_if adc_link ();

    assign adc_link.code = adc_code_in;

    pia_addr_offset u_offset (
        .adc (adc_link.mapper)
    );

    // offset taken once per power-up from the converter result
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            offset_reg <= 4'h0;
            addr_read_reg <= 1'b0;
        end
        else if (!supplies_good)
        begin
            addr_read_reg <= 1'b0;
        end
        else if (state_reg == pia_pkg::ST_ADC_WAIT && adc_done_in)
        begin
            offset_reg <= adc_link.offset;
            addr_read_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // working configuration registers
    // ------------------------------------------------------------
    logic [7:0] cfg_reg [pia_pkg::CFG_WORDS];
    logic mgmt_wr_ok;

    // writes refused until the load completes, then enable plays no part
    assign mgmt_wr_ok = mgmt_wr_in && load_done_reg
                     && (mgmt_index_in != pia_pkg::IDX_STATUS);

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            cfg_reg[pia_pkg::IDX_TWOWIRE_BASE] <= pia_pkg::TWOWIRE_BASE_RESET;
            cfg_reg[pia_pkg::IDX_POWER_BUS_BASE] <= pia_pkg::POWER_BUS_BASE_RESET;
            cfg_reg[pia_pkg::IDX_CONV_CTRL] <= pia_pkg::CONV_CTRL_RESET;
        end
        else if (state_reg == pia_pkg::ST_LOAD_REQ && nvm_ack_in)
        begin
            cfg_reg[load_idx_reg] <= nvm_data_in;
        end
        else if (mgmt_wr_ok)
        begin
            cfg_reg[mgmt_index_in] <= mgmt_wdata_in;
        end
    end

    logic [6:0] twowire_base;
    logic [6:0] power_bus_base;
    logic sw_override;
    logic sw_on;

    // two independent 7-bit bases; bit 7 of each word reads back as stored
    assign twowire_base = cfg_reg[pia_pkg::IDX_TWOWIRE_BASE][6:0];
    assign power_bus_base = cfg_reg[pia_pkg::IDX_POWER_BUS_BASE][6:0];
    assign sw_override = cfg_reg[pia_pkg::IDX_CONV_CTRL][pia_pkg::CTRL_SW_OVERRIDE_BIT];
    assign sw_on = cfg_reg[pia_pkg::IDX_CONV_CTRL][pia_pkg::CTRL_SW_ON_BIT];

    // ------------------------------------------------------------
    // bus addresses and enables
    // ------------------------------------------------------------
    logic [6:0] twowire_addr_reg;
    logic [6:0] power_bus_addr_reg;
    logic twowire_en_reg;
    logic power_bus_en_reg;

    // sum wraps inside 7 bits; a base near the top plus offset will alias low
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            twowire_addr_reg <= 7'h00;
            power_bus_addr_reg <= 7'h00;
        end
        else
        begin
            twowire_addr_reg <= 7'(twowire_base + 7'(offset_reg));
            power_bus_addr_reg <= 7'(power_bus_base + 7'(offset_reg));
        end
    end

    // base of zero silences that bus only
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            twowire_en_reg <= 1'b0;
            power_bus_en_reg <= 1'b0;
        end
        else
        begin
            twowire_en_reg <= addr_read_reg && (twowire_base != 7'h00);
            power_bus_en_reg <= addr_read_reg && (power_bus_base != 7'h00);
        end
    end

    logic hit_reg;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            hit_reg <= 1'b0;
        else if (!bus_addr_valid_in)
            hit_reg <= 1'b0;
        else if (bus_is_power_bus_in)
            hit_reg <= power_bus_en_reg && (bus_addr_in == power_bus_addr_reg);
        else
            hit_reg <= twowire_en_reg && (bus_addr_in == twowire_addr_reg);
    end

    // ------------------------------------------------------------
    // conversion gate
    // ------------------------------------------------------------
    logic start_cond;
    logic conv_on_reg;

    // software option replaces only the enable pin term
    assign start_cond = (sw_override ? sw_on : mon_sync_reg[pia_pkg::MON_ENABLE])
                      && mon_sync_reg[pia_pkg::MON_VIN]
                      && load_done_reg
                      && addr_read_reg;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            conv_on_reg <= 1'b0;
        else
            conv_on_reg <= start_cond;
    end

    // ------------------------------------------------------------
    // management readback
    // ------------------------------------------------------------
    logic [7:0] status_word;
    logic [7:0] rdata_reg;
    logic rvalid_reg;

    always_comb
    begin
        status_word = 8'h00;
        status_word[pia_pkg::STAT_OFFSET_LSB +: pia_pkg::OFFSET_WIDTH] = offset_reg;
        status_word[pia_pkg::STAT_ADDR_READ_BIT] = addr_read_reg;
        status_word[pia_pkg::STAT_LOAD_DONE_BIT] = load_done_reg;
        status_word[pia_pkg::STAT_CONV_ON_BIT] = conv_on_reg;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= mgmt_rd_in;
            if (mgmt_rd_in)
            begin
                if (mgmt_index_in == pia_pkg::IDX_STATUS)
                    rdata_reg <= status_word;
                else
                    rdata_reg <= cfg_reg[mgmt_index_in];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic por_reg;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            por_reg <= 1'b1;
        else
            por_reg <= (state_next == pia_pkg::ST_POR);
    end

    assign nvm_rd_out = nvm_rd_reg;
    assign nvm_index_out = load_idx_reg;
    assign adc_start_out = adc_start_reg;
    assign mgmt_rdata_out = rdata_reg;
    assign mgmt_rvalid_out = rvalid_reg;
    assign bus_addr_hit_out = hit_reg;
    assign por_active_out = por_reg;
    assign load_done_out = load_done_reg;
    assign addr_read_out = addr_read_reg;
    assign conversion_on_out = conv_on_reg;
    assign twowire_addr_out = twowire_addr_reg;
    assign power_bus_addr_out = power_bus_addr_reg;
    assign twowire_enabled_out = twowire_en_reg;
    assign power_bus_enabled_out = power_bus_en_reg;

endmodule : pia_powerup_init

/* File: common/pia_pkg.sv */
// shared constants and types for the power-up init and address setup block
package pia_pkg;

    // ------------------------------------------------------------
    // working configuration layout
    // ------------------------------------------------------------
    localparam int CFG_WIDTH = 8;
    localparam int CFG_WORDS = 3;
    localparam int IDX_WIDTH = 2;
    localparam logic [1:0] IDX_TWOWIRE_BASE = 2'h0;
    localparam logic [1:0] IDX_POWER_BUS_BASE = 2'h1;
    localparam logic [1:0] IDX_CONV_CTRL = 2'h2;
    localparam logic [1:0] IDX_STATUS = 2'h3;
    localparam logic [1:0] IDX_LAST_LOADED = 2'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ADDR_WIDTH = 7;
    localparam int CTRL_SW_OVERRIDE_BIT = 0;
    localparam int CTRL_SW_ON_BIT = 1;
    localparam int STAT_OFFSET_LSB = 0;
    localparam int STAT_ADDR_READ_BIT = 4;
    localparam int STAT_LOAD_DONE_BIT = 5;
    localparam int STAT_CONV_ON_BIT = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TWOWIRE_BASE_RESET = 8'h10;
    localparam logic [7:0] POWER_BUS_BASE_RESET = 8'h40;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // address offset converter
    // ------------------------------------------------------------
    localparam int ADC_WIDTH = 10;
    localparam int OFFSET_WIDTH = 4;
    localparam int OFFSET_RANGES = 16;
    localparam logic [9:0] ADC_RANGE_STEP = 10'h040;

    // ------------------------------------------------------------
    // monitor synchroniser lanes
    // ------------------------------------------------------------
    localparam int MON_LANES = 5;
    localparam int MON_BIAS = 0;
    localparam int MON_CORE = 1;
    localparam int MON_OSC = 2;
    localparam int MON_ENABLE = 3;
    localparam int MON_VIN = 4;

    typedef enum logic [2:0] {
        ST_POR,
        ST_LOAD_REQ,
        ST_ADC_START,
        ST_ADC_WAIT,
        ST_READY
    } pia_state_e;

endpackage : pia_pkg

/* File: common/pia_adc_if.sv */
// carrier between the init sequencer and the address offset mapper
`timescale 1ns/100ps
interface pia_adc_if;
    logic [9:0] code;
    logic [3:0] offset;

    modport mapper (
        input code,
        output offset
    );

    modport user (
        output code,
        input offset
    );
endinterface : pia_adc_if

/* File: rtl/pia_addr_offset.sv */
// maps the converter reading of the address resistor to a 4-bit offset
`timescale 1ns/100ps
module pia_addr_offset (
    // converter side
    pia_adc_if.mapper adc
);

    // ------------------------------------------------------------
    // range compare
    // ------------------------------------------------------------
    logic [pia_pkg::OFFSET_RANGES-1:0] above;

    // range 0 has threshold zero and is always reached
    genvar k;
    generate
        for (k = 0; k < pia_pkg::OFFSET_RANGES; k++)
        begin : g_range
            localparam logic [9:0] THRESH = 10'(k * pia_pkg::ADC_RANGE_STEP);
            assign above[k] = (adc.code >= THRESH);
        end
    endgenerate

    // ------------------------------------------------------------
    // count ranges passed
    // ------------------------------------------------------------
    always_comb
    begin
        logic [4:0] count;
        count = 5'h00;
        for (int i = 1; i < pia_pkg::OFFSET_RANGES; i++)
        begin
            count = count + 5'(above[i]);
        end
        // first range gives offset zero, last gives fifteen
        adc.offset = count[3:0];
    end

endmodule : pia_addr_offset

/* File: rtl/pia_note_unused.sv */
// holds no logic

/* File: verification/pia_init_props.sv */
// port checker for the power-up sequencer
`timescale 1ns/100ps
module pia_init_props (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // monitors
    input wire logic bias_rail_ok_in,
    input wire logic core_rail_1v8_ok_in,
    input wire logic osc_stable_in,
    input wire logic input_rail_ok_in,
    // store and converter
    input wire logic nvm_rd_out,
    input wire logic [1:0] nvm_index_out,
    input wire logic nvm_ack_in,
    input wire logic adc_start_out,
    input wire logic adc_done_in,
    // management and filter
    input wire logic mgmt_rd_in,
    input wire logic mgmt_rvalid_out,
    input wire logic bus_addr_valid_in,
    input wire logic bus_is_power_bus_in,
    input wire logic [6:0] bus_addr_in,
    input wire logic bus_addr_hit_out,
    // status
    input wire logic por_active_out,
    input wire logic load_done_out,
    input wire logic addr_read_out,
    input wire logic conversion_on_out,
    input wire logic [6:0] twowire_addr_out,
    input wire logic [6:0] power_bus_addr_out
);
    logic supply_ok;
    assign supply_ok = bias_rail_ok_in & core_rail_1v8_ok_in & osc_stable_in;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    // six cycles covers the synchroniser plus state register
    sequence s_supply_low;
        (!supply_ok) [*6];
    endsequence
    sequence s_rd_wait;
        nvm_rd_out && !nvm_ack_in && !por_active_out;
    endsequence
    a_por_on_drop: assert property (s_supply_low |-> por_active_out)
        else $error("reset not held with a supply low");
    a_rd_held: assert property (s_rd_wait |=> nvm_rd_out || por_active_out)
        else $error("store read dropped before ack");
    a_index_range: assert property (nvm_rd_out |-> nvm_index_out <= pia_pkg::IDX_LAST_LOADED)
        else $error("store index out of range");
    a_start_after_load: assert property (adc_start_out |-> load_done_out ##1 !adc_start_out)
        else $error("converter start not a pulse after load");
    a_done_sets_read: assert property (adc_done_in && !por_active_out |=> addr_read_out)
        else $error("address read flag not set");
    a_conv_gate: assert property (conversion_on_out |->
        (load_done_out && addr_read_out) || $past(load_done_out && addr_read_out))
        else $error("conversion before load and address read");
    a_vin_gate: assert property ((!input_rail_ok_in) [*6] |-> !conversion_on_out)
        else $error("conversion with input rail low");
    a_hit_match: assert property (bus_addr_hit_out |-> $past(bus_addr_valid_in) &&
        $past(bus_addr_in) == ($past(bus_is_power_bus_in) ?
        $past(power_bus_addr_out) : $past(twowire_addr_out)))
        else $error("address hit without match");
    a_rvalid_follow: assert property (mgmt_rd_in |=> mgmt_rvalid_out)
        else $error("read answer missing");
    a_rvalid_cause: assert property (mgmt_rvalid_out |-> $past(mgmt_rd_in))
        else $error("read answer without request");
endmodule : pia_init_props

/* File: verification/pia_store_model.sv */
// nonvolatile store and address resistor converter model
`timescale 1ns/100ps
module pia_store_model #(
    parameter logic [7:0] W0 = 8'h10,
    parameter logic [7:0] W1 = 8'h40,
    parameter logic [7:0] W2 = 8'h00
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // store port
    input wire logic rd_in,
    input wire logic [1:0] index_in,
    output logic ack_out,
    output logic [7:0] data_out,
    // converter port
    input wire logic start_in,
    input wire logic slow_in,
    input wire logic [9:0] code_in,
    output logic done_out,
    output logic [9:0] code_out
);
    logic [7:0] words [3];
    logic [2:0] cnt_reg, acnt_reg, lat;
    logic served_reg, busy_reg;
    assign words = '{W0, W1, W2};
    assign lat = slow_in ? 3'h5 : 3'h0;
    // ------------------------------------------------------------
    // store: one pulse per request, stale bus inverted
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        ack_out <= 1'h0;
        data_out <= rst_in ? 8'h00 : ~data_out;
        if (!rd_in)
            served_reg <= 1'h0;
        if (rst_in)
            {cnt_reg, served_reg} <= 4'h0;
        else if (rd_in && !served_reg)
        begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg >= lat)
            begin
                ack_out <= 1'h1;
                data_out <= words[index_in];
                served_reg <= 1'h1;
                cnt_reg <= 3'h0;
            end
        end
    end
    // converter: 10-bit reading of the address resistor
    always_ff @(posedge clk_in)
    begin
        done_out <= 1'h0;
        code_out <= rst_in ? 10'h000 : ~code_out;
        if (rst_in)
            {busy_reg, acnt_reg} <= 4'h0;
        else if (start_in)
            {busy_reg, acnt_reg} <= 4'h8;
        else if (busy_reg)
        begin
            acnt_reg <= acnt_reg + 3'h1;
            if (acnt_reg >= lat)
            begin
                done_out <= 1'h1;
                code_out <= code_in;
                busy_reg <= 1'h0;
            end
        end
    end
endmodule : pia_store_model

/* File: verification/test_powerup_init_address_setup.sv */
// self-checking bench for the power-up sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, g, e); end end
module test_powerup_init_address_setup;
    logic ref_clk_in = 1'h0, rst_in = 1'h1, enable_ok_in = 1'h0, input_rail_ok_in = 1'h1;
    logic bias_rail_ok_in = 1'h0, core_rail_1v8_ok_in = 1'h0, osc_stable_in = 1'h0;
    logic nvm_rd_out, nvm_ack_in, adc_start_out, adc_done_in, mgmt_rvalid_out;
    logic [1:0] nvm_index_out;
    logic [7:0] nvm_data_in, mgmt_rdata_out;
    logic [9:0] adc_code_in, res_code = 10'h000;
    logic mgmt_wr_in = 1'h0, mgmt_rd_in = 1'h0, bus_addr_valid_in = 1'h0, slow = 1'h0;
    logic bus_is_power_bus_in = 1'h0;
    logic [1:0] mgmt_index_in = 2'h0;
    logic [7:0] mgmt_wdata_in = 8'h00;
    logic [6:0] bus_addr_in = 7'h00, twowire_addr_out, power_bus_addr_out;
    logic bus_addr_hit_out, por_active_out, load_done_out, addr_read_out;
    logic conversion_on_out, twowire_enabled_out, power_bus_enabled_out;
    int bad_count = 0, total_checks = 0;
    pia_powerup_init uut (.*);
    pia_store_model u_store (.clk_in(ref_clk_in), .rst_in(rst_in), .rd_in(nvm_rd_out),
        .index_in(nvm_index_out), .ack_out(nvm_ack_in), .data_out(nvm_data_in),
        .start_in(adc_start_out), .slow_in(slow), .code_in(res_code),
        .done_out(adc_done_in), .code_out(adc_code_in));
    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // ------------------------------------------------------------
    // bus and supply tasks
    // ------------------------------------------------------------
    task tick;
        @(posedge ref_clk_in);
        #1;
    endtask : tick
    task mg_write(input logic [1:0] idx, input logic [7:0] d);
        {mgmt_index_in, mgmt_wdata_in, mgmt_wr_in} = {idx, d, 1'h1};
        tick();
        mgmt_wr_in = 1'h0;
        repeat (3) tick();
    endtask : mg_write
    task mg_read(input logic [1:0] idx, input logic [7:0] e);
        {mgmt_index_in, mgmt_rd_in} = {idx, 1'h1};
        tick();
        mgmt_rd_in = 1'h0;
        `CHK(mgmt_rvalid_out, 1'h1)
        `CHK(mgmt_rdata_out, e)
        tick();
    endtask : mg_read
    task probe(input logic pb, input logic [6:0] a, input logic e);
        {bus_is_power_bus_in, bus_addr_in, bus_addr_valid_in} = {pb, a, 1'h1};
        tick();
        bus_addr_valid_in = 1'h0;
        `CHK(bus_addr_hit_out, e)
        tick();
    endtask : probe
    task power_up(input logic [9:0] code);
        res_code = code;
        {bias_rail_ok_in, core_rail_1v8_ok_in, osc_stable_in} = 3'h7;
        for (int i = 0; i < 200 && addr_read_out !== 1'h1; i++)
            tick();
        repeat (2) tick();
        `CHK(load_done_out, 1'h1)
        `CHK(addr_read_out, 1'h1)
    endtask : power_up
    task power_down;
        {bias_rail_ok_in, core_rail_1v8_ok_in, osc_stable_in, enable_ok_in} = 4'h0;
        repeat (8) tick();
        `CHK(por_active_out, 1'h1)
        `CHK(load_done_out, 1'h0)
    endtask : power_down
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_por;
        `CHK(por_active_out, 1'h1)
        for (int i = 0; i < 3; i++)
        begin
            {bias_rail_ok_in, core_rail_1v8_ok_in, osc_stable_in} = 3'(~(3'h1 << i));
            repeat (8) tick();
            `CHK(por_active_out, 1'h1)
            `CHK(nvm_rd_out, 1'h0)
        end
    endtask : t_por
    task t_load;
        power_up(10'h03F);
        `CHK(twowire_addr_out, 7'h10)
        `CHK(power_bus_addr_out, 7'h40)
        mg_read(2'h3, 8'h30);
        mg_read(2'h1, 8'h40);
    endtask : t_load
    task t_conv;
        // bias is already up, so raising enable now keeps the host ordering
        {enable_ok_in, input_rail_ok_in} = 2'h2;
        repeat (5) tick();
        `CHK(conversion_on_out, 1'h0)
        input_rail_ok_in = 1'h1;
        repeat (5) tick();
        `CHK(conversion_on_out, 1'h1)
        mg_read(2'h3, 8'h70);
        enable_ok_in = 1'h0;
        mg_write(2'h2, 8'h03);
        `CHK(conversion_on_out, 1'h1)
        input_rail_ok_in = 1'h0;
        repeat (5) tick();
        `CHK(conversion_on_out, 1'h0)
        input_rail_ok_in = 1'h1;
        mg_write(2'h2, 8'h01);
        repeat (2) tick();
        `CHK(conversion_on_out, 1'h0)
        mg_write(2'h2, 8'h00);
    endtask : t_conv
    task t_mgmt;
        mg_write(2'h0, 8'h00);
        `CHK(twowire_enabled_out, 1'h0)
        probe(1'h0, 7'h00, 1'h0);
        probe(1'h1, 7'h40, 1'h1);
        mg_write(2'h0, 8'h25);
        mg_write(2'h1, 8'h00);
        `CHK(power_bus_enabled_out, 1'h0)
        probe(1'h1, 7'h00, 1'h0);
        probe(1'h0, 7'h25, 1'h1);
        probe(1'h0, 7'h26, 1'h0);
        mg_read(2'h0, 8'h25);
        mg_write(2'h3, 8'hFF);
        mg_read(2'h3, 8'h30);
        mg_write(2'h1, 8'h40);
        mg_read(2'h1, 8'h40);
    endtask : t_mgmt
    task t_reload;
        mg_write(2'h0, 8'h22);
        power_down();
        power_up(10'h040);
        `CHK(twowire_addr_out, 7'h11)
        mg_read(2'h0, 8'h10);
    endtask : t_reload
    task t_offsets;
        for (int k = 0; k < 16; k++)
        begin
            // odd steps use the far edge of each range and a slow store
            slow = k[0];
            power_down();
            power_up(10'(k * 64 + (k[0] ? 63 : 0)));
            `CHK(twowire_addr_out, 7'(7'h10 + k))
            `CHK(power_bus_addr_out, 7'(7'h40 + k))
        end
    endtask : t_offsets
    task results;
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    initial
    begin
        #200000;
        bad_count++;
        results();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk_in);
        #1;
        `CHK(por_active_out, 1'h1)
        rst_in = 1'h0;
        t_por();
        t_por();
        t_load();
        t_conv();
        t_mgmt();
        t_reload();
        t_offsets();
        results();
    end
endmodule : test_powerup_init_address_setup
bind pia_powerup_init pia_init_props u_props (.*);
